//--- design/tcs_regs.svh
// Register offsets, field positions, reset values and divider taps
`ifndef TCS_REGS_SVH
`define TCS_REGS_SVH
`define TCS_START_OFS 8'h00
`define TCS_SYNC_OFS 8'h04
`define TCS_CH_BASE 8'h10
`define TCS_CH_STRIDE 8'h10
`define TCS_CTRL_OFS 8'h00
`define TCS_MODE_OFS 8'h04
`define TCS_COUNT_OFS 8'h08
`define TCS_CLR_MSB 7
`define TCS_CLR_LSB 5
`define TCS_EDGE_MSB 4
`define TCS_EDGE_LSB 3
`define TCS_PSC_MSB 2
`define TCS_PSC_LSB 0
`define TCS_MODE_BUFA 0
`define TCS_MODE_BUFB 1
`define TCS_MODE_PHASE 2
`define TCS_CTRL_RST 8'h00
`define TCS_MODE_RST 3'h0
`define TCS_WAIT_RST 1'h1
`define TCS_TAP_DIV64 4'h5
`define TCS_TAP_DIV256 4'h7
`define TCS_TAP_DIV1024 4'h9
`define TCS_TAP_DIV4096 4'hb
`define TCS_PIN_A 4'h0
`define TCS_PIN_B 4'h1
`define TCS_PIN_C 4'h2
`define TCS_PIN_D 4'h3
`endif

//--- design/tcs_pkg.sv
// Types shared by the timer clock and clear select block
package tcs_pkg;
  typedef enum logic [1:0] {SRC_P1, SRC_INT, SRC_EXT, SRC_OVF} tcs_kind_t;
  typedef struct packed {
    tcs_kind_t kind;
    logic [3:0] idx;
  } tcs_src_t;
  typedef struct packed {
    logic [7:0] addr;
    logic rd;
    logic wr;
    logic [31:0] wdata;
  } tcs_bus_t;
  typedef struct packed {
    logic waitreq;
    logic [31:0] rdata;
    logic [5:0][7:0] ctrl;
    logic [5:0][2:0] mode;
    logic [5:0][15:0] cnt;
    logic [5:0] start;
    logic [5:0] sync;
    logic [11:0] div;
    logic [3:0] pin_s1;
    logic [3:0] pin_s2;
    logic [3:0] pin_s3;
    logic [3:0] pin_filt;
    logic [5:0] cleared;
  } tcs_state_t;
endpackage

//--- design/tcs_top.sv
// Six-channel counter with clock source, edge and clear source select
//
// Overview of operation
// - Ch0/3 codes 000,100 no clear; 001 clears on A, 010 on B event.
// - Ch0/3 code 101 clears on C event, 110 clears on D event.
// - Codes 011 and ch0/3 111 clear when a synced channel clears.
// - A channel joins synchronous clearing only while its sync bit is 1.
// - Buffer-mode C or D gives no event, so never clears the counter.
// - Ch1,2,4,5 clear field top bit reads zero and ignores writes.
// - Ch1,2,4,5: 00 none, 01 A, 10 B, 11 synchronous clear.
// - Edge 00 internal falling/external rising; 01 the reverse.
// - Upper edge bit set counts both edges; lower bit ignored.
// - Ch0 prescale 000,001,010 pick clock divided by 1, 4, 16.
// - Ch0 prescale 100 to 111 pick external pins A, B, C, D.
// - Ch1: /1,/4,/16,/64, pin A, pin B, /256, ch2 overflow.
// - Ch2: /1,/4,/16,/64, pin A, pin B, pin C, /1024.
// - Ch3: 000 /1, 001 /4, 100 pin A, 110 /256, 111 /4096.
// - Ch4: /1,/4,/16,/64, pin A, pin C, /1024, ch5 overflow.
// - Ch5: /1,/4,/16,/64, pin A, pin C, /256, pin D.
// - Phase counting on ch1,2,4,5 overrides the prescale choice.
// - Edge select ignored for undivided clock and overflow source.
`timescale 1ns/1ps
`include "tcs_regs.svh"

module tcs_top
  import tcs_pkg::*;
(
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RESET,
  // Avalon-MM slave
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // External clock pins A..D
  input wire logic [3:0] EXT_CLK_PIN,
  // Per channel events {D,C,B,A} and phase count pulses
  input wire logic [5:0][3:0] MATCH_EVT,
  input wire logic [5:0] PHASE_CNT,
  // Per channel counter-cleared pulse
  output logic [5:0] CLEARED
);

  ////////////////////////////////////////////////////////////////////////
  function automatic logic is_wide(input logic [2:0] ch);
    return (ch == 3'h0) || (ch == 3'h3);
  endfunction

  function automatic logic [7:0] reg_addr(input logic [2:0] ch,
                                          input logic [7:0] ofs);
    return 8'(`TCS_CH_BASE + 8'(ch) * `TCS_CH_STRIDE + ofs);
  endfunction

  function automatic logic cnt_edge(input logic ext, input logic [1:0] eg,
                                    input logic prev, input logic now);
    logic rise;
    logic fall;
    rise = !prev && now;
    fall = prev && !now;
    if (eg[1]) begin
      return rise || fall;
    end
    // Internal and external sense opposite edges per code
    return (eg[0] ^ ext) ? rise : fall;
  endfunction

  function automatic tcs_src_t src_sel(input logic [2:0] ch,
                                       input logic [2:0] p);
    tcs_src_t s;
    s = '{SRC_INT, 4'(4'({p[1:0], 1'b0}) - 4'h1)};
    if (!p[2]) begin
      if (p == 3'h0) begin
        s.kind = SRC_P1;
      end
      return s;
    end
    if (p[1:0] == 2'h0) begin
      return '{SRC_EXT, `TCS_PIN_A};
    end
    unique case (ch)
      3'h0: s = '{SRC_EXT, 4'(p[1:0])};
      3'h1: s = (p[1:0] == 2'h1) ? '{SRC_EXT, `TCS_PIN_B} :
                (p[1:0] == 2'h2) ? '{SRC_INT, `TCS_TAP_DIV256} :
                '{SRC_OVF, 4'h2};
      3'h2: s = (p[1:0] == 2'h1) ? '{SRC_EXT, `TCS_PIN_B} :
                (p[1:0] == 2'h2) ? '{SRC_EXT, `TCS_PIN_C} :
                '{SRC_INT, `TCS_TAP_DIV1024};
      3'h3: s = (p[1:0] == 2'h1) ? '{SRC_INT, `TCS_TAP_DIV1024} :
                (p[1:0] == 2'h2) ? '{SRC_INT, `TCS_TAP_DIV256} :
                '{SRC_INT, `TCS_TAP_DIV4096};
      3'h4: s = (p[1:0] == 2'h1) ? '{SRC_EXT, `TCS_PIN_C} :
                (p[1:0] == 2'h2) ? '{SRC_INT, `TCS_TAP_DIV1024} :
                '{SRC_OVF, 4'h5};
      default: s = (p[1:0] == 2'h1) ? '{SRC_EXT, `TCS_PIN_C} :
                   (p[1:0] == 2'h2) ? '{SRC_INT, `TCS_TAP_DIV256} :
                   '{SRC_EXT, `TCS_PIN_D};
    endcase
    return s;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  tcs_state_t s_q;
  tcs_state_t s_d;
  tcs_bus_t bus;
  tcs_src_t src;
  logic go_wr;
  logic tick;
  logic [3:0] evt;
  logic [2:0] code;
  logic [5:0] own_clr;
  logic [5:0] clr;
  logic [5:0] inc;
  logic [5:0] ovf;
  logic [5:0] wr_cnt;

  assign bus = '{AVS_ADDRESS, AVS_READ, AVS_WRITE, AVS_WRITEDATA};
  assign AVS_READDATA = s_q.rdata;
  assign AVS_WAITREQUEST = s_q.waitreq;
  assign CLEARED = s_q.cleared;

  always_comb begin
    s_d = s_q;
    src = '{SRC_P1, 4'h0};
    tick = 1'b0;
    evt = 4'h0;
    code = 3'h0;
    own_clr = 6'h00;
    clr = 6'h00;
    inc = 6'h00;
    ovf = 6'h00;
    wr_cnt = 6'h00;
    // One wait cycle, then the request is taken with waitrequest low
    go_wr = bus.wr && !s_q.waitreq;
    s_d.waitreq = !((bus.rd || bus.wr) && s_q.waitreq);
    if (bus.rd && s_q.waitreq) begin
      s_d.rdata = 32'h0;
      if (bus.addr == `TCS_START_OFS) s_d.rdata[5:0] = s_q.start;
      if (bus.addr == `TCS_SYNC_OFS) s_d.rdata[5:0] = s_q.sync;
      for (int ch = 0; ch < 6; ch++) begin
        if (bus.addr == reg_addr(3'(ch), `TCS_CTRL_OFS))
          s_d.rdata[7:0] = s_q.ctrl[ch];
        if (bus.addr == reg_addr(3'(ch), `TCS_MODE_OFS))
          s_d.rdata[2:0] = s_q.mode[ch];
        if (bus.addr == reg_addr(3'(ch), `TCS_COUNT_OFS))
          s_d.rdata[15:0] = s_q.cnt[ch];
      end
    end
    s_d.div = s_q.div + 12'h001;
    // Pin filter: a level counts once the last two stages agree
    s_d.pin_s1 = EXT_CLK_PIN;
    s_d.pin_s2 = s_q.pin_s1;
    s_d.pin_s3 = s_q.pin_s2;
    for (int i = 0; i < 4; i++) begin
      if (s_q.pin_s2[i] == s_q.pin_s3[i]) s_d.pin_filt[i] = s_q.pin_s3[i];
    end
    if (go_wr) begin
      if (bus.addr == `TCS_START_OFS) s_d.start = bus.wdata[5:0];
      if (bus.addr == `TCS_SYNC_OFS) s_d.sync = bus.wdata[5:0];
      for (int ch = 0; ch < 6; ch++) begin
        if (bus.addr == reg_addr(3'(ch), `TCS_CTRL_OFS))
          s_d.ctrl[ch] = is_wide(3'(ch)) ? bus.wdata[7:0] :
                         {1'b0, bus.wdata[6:0]};
        if (bus.addr == reg_addr(3'(ch), `TCS_MODE_OFS))
          s_d.mode[ch] = is_wide(3'(ch)) ? {1'b0, bus.wdata[1:0]} :
                         {bus.wdata[2], 2'b00};
        wr_cnt[ch] = bus.addr == reg_addr(3'(ch), `TCS_COUNT_OFS);
      end
    end
    // Own clear sources; buffer-mode C/D raise no event
    for (int ch = 0; ch < 6; ch++) begin
      evt = MATCH_EVT[ch] & {~s_q.mode[ch][`TCS_MODE_BUFB],
                             ~s_q.mode[ch][`TCS_MODE_BUFA], 2'b11};
      code = s_q.ctrl[ch][`TCS_CLR_MSB:`TCS_CLR_LSB];
      unique case (code)
        3'b001: own_clr[ch] = evt[0];
        3'b010: own_clr[ch] = evt[1];
        3'b101: own_clr[ch] = evt[2];
        3'b110: own_clr[ch] = evt[3];
        default: own_clr[ch] = 1'b0;
      endcase
    end
    for (int ch = 0; ch < 6; ch++) begin
      code = s_q.ctrl[ch][`TCS_CLR_MSB:`TCS_CLR_LSB];
      clr[ch] = own_clr[ch] || (s_q.sync[ch] && code[1:0] == 2'b11 &&
                |(own_clr & s_q.sync & ~(6'h01 << ch)));
    end
    // Descending so a neighbour's overflow is known before use
    for (int ch = 5; ch >= 0; ch--) begin
      src = src_sel(3'(ch), s_q.ctrl[ch][`TCS_PSC_MSB:`TCS_PSC_LSB]);
      unique case (src.kind)
        SRC_P1: tick = 1'b1;
        SRC_INT: tick = cnt_edge(1'b0,
                   s_q.ctrl[ch][`TCS_EDGE_MSB:`TCS_EDGE_LSB],
                   s_q.div[src.idx], s_d.div[src.idx]);
        SRC_EXT: tick = cnt_edge(1'b1,
                   s_q.ctrl[ch][`TCS_EDGE_MSB:`TCS_EDGE_LSB],
                   s_q.pin_filt[src.idx[1:0]],
                   s_d.pin_filt[src.idx[1:0]]);
        SRC_OVF: tick = ovf[src.idx[2:0]];
      endcase
      if (!is_wide(3'(ch)) && s_q.mode[ch][`TCS_MODE_PHASE])
        tick = PHASE_CNT[ch];
      inc[ch] = s_q.start[ch] && tick;
      if (wr_cnt[ch]) begin
        s_d.cnt[ch] = bus.wdata[15:0];
      end else if (clr[ch]) begin
        s_d.cnt[ch] = 16'h0000;
      end else if (inc[ch]) begin
        s_d.cnt[ch] = s_q.cnt[ch] + 16'h0001;
      end
      ovf[ch] = inc[ch] && !clr[ch] && !wr_cnt[ch] &&
                s_q.cnt[ch] == 16'hffff;
    end
    s_d.cleared = clr;
  end

  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      s_q <= '0;
      s_q.waitreq <= `TCS_WAIT_RST;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (RESET);

  a_ch0_no_clear: assert property (s_q.ctrl[0][7:5] inside {3'b000, 3'b100}
    |-> !clr[0]) else $error("ch0 cleared with clearing off");
  a_ch0_clear_a: assert property (s_q.ctrl[0][7:5] == 3'b001 &&
    MATCH_EVT[0][0] && !wr_cnt[0] |=> s_q.cnt[0] == 16'h0000)
    else $error("ch0 not cleared by A event");
  a_ch3_clear_d: assert property (s_q.ctrl[3][7:5] == 3'b110 &&
    MATCH_EVT[3][3] && !s_q.mode[3][1] |-> clr[3])
    else $error("ch3 not cleared by D event");
  a_sync_clear: assert property (s_q.ctrl[0][7:5] == 3'b001 &&
    MATCH_EVT[0][0] && s_q.sync[0] && s_q.sync[2] &&
    s_q.ctrl[2][6:5] == 2'b11 |=> CLEARED[2])
    else $error("ch2 missed synchronous clear");
  a_unsync_hold: assert property (s_q.ctrl[2][6:5] == 2'b11 &&
    !s_q.sync[2] |-> !clr[2]) else $error("unsynced ch2 cleared");
  a_buffer_no_clr: assert property (s_q.ctrl[0][7:5] == 3'b101 &&
    s_q.mode[0][0] |-> !clr[0]) else $error("buffer C cleared");
  a_reserved_top: assert property (!s_q.ctrl[1][7] && !s_q.ctrl[2][7] &&
    !s_q.ctrl[4][7] && !s_q.ctrl[5][7])
    else $error("reserved clear bit set");
  a_ch1_clear_b: assert property (s_q.ctrl[1][6:5] == 2'b10 &&
    MATCH_EVT[1][1] |-> clr[1]) else $error("ch1 B clear lost");
  a_edge_falling: assert property (s_q.ctrl[2][4:0] == 5'b00001 && inc[2]
    |-> s_q.div[1] && !s_d.div[1]) else $error("ch2 wrong edge");
  a_edge_both: assert property (s_q.ctrl[2][4] &&
    s_q.ctrl[2][2:0] == 3'b001 && !s_q.mode[2][2] && s_q.start[2] &&
    s_q.div[1] != s_d.div[1] |-> inc[2])
    else $error("ch2 missed an edge");
  a_div1_count: assert property (s_q.ctrl[0][2:0] == 3'b000 &&
    s_q.start[0] && !clr[0] && !wr_cnt[0] |=>
    s_q.cnt[0] == 16'($past(s_q.cnt[0]) + 16'h0001))
    else $error("ch0 did not step");
  a_ovf_chain: assert property (s_q.ctrl[1][2:0] == 3'b111 &&
    !s_q.mode[1][2] && s_q.start[1] |-> inc[1] == ovf[2])
    else $error("ch1 not tied to ch2 overflow");
  a_phase_ignore: assert property (s_q.mode[1][2] |->
    inc[1] == (s_q.start[1] && PHASE_CNT[1]))
    else $error("phase mode ignored");

  c_sync_clear: cover property (CLEARED[0] && CLEARED[2]);
  c_ovf_step: cover property (ovf[2] && inc[1]);
  c_ext_count: cover property (s_q.ctrl[0][2] && inc[0]);
  c_bus_write: cover property (go_wr);

endmodule

//--- tb/tcs_partner.sv
// Far-side model: external clock pins, match events, phase pulses
`timescale 1ns/1ps
module tcs_partner (
  // Clock
  input wire logic clk,
  // Toward the timer
  output logic [3:0] pin,
  output logic [5:0][3:0] evt,
  output logic [5:0] phase
);
  initial begin
    pin = 4'h0;
    evt = 24'h0;
    phase = 6'h00;
  end
  // Pins are level lines, so they keep their last state between bursts
  task automatic clk_pin(input int p, input int k, input int half);
    repeat (k) begin
      repeat (half) @(posedge clk);
      pin[p] <= ~pin[p];
    end
  endtask
  // One-cycle pulse of event bits or of a phase step
  task automatic pulse(input int ch, input logic [3:0] b, input bit ph);
    @(posedge clk);
    if (ph) begin
      phase[ch] <= 1'b1;
    end else begin
      evt[ch] <= b;
    end
    @(posedge clk);
    evt[ch] <= 4'h0;
    phase[ch] <= 1'b0;
  endtask
endmodule

//--- tb/tcs_top_bench.sv
// Self-checking bench for the timer clock and clear select block
`timescale 1ns/1ps
`include "tcs_regs.svh"
module tcs_top_bench
  import tcs_pkg::*;
;
  logic clk, rst, rd, wr, waitreq;
  logic [7:0] addr;
  logic [31:0] wd, rdat, q;
  logic [3:0] pin;
  logic [5:0][3:0] evt;
  logic [5:0] phase, cleared;
  logic [15:0] lfsr = 16'h0060;
  int miscompares = 0, comparisons = 0, n, e0;
  int ncl[6];
  int tch[6] = '{0, 2, 0, 2, 2, 3};
  int tcd[6] = '{0, 1, 2, 3, 7, 6};
  int tdv[6] = '{1, 4, 16, 64, 1024, 256};
  int xch[9] = '{0, 0, 0, 0, 1, 2, 3, 4, 5};
  int xcd[9] = '{4, 5, 6, 7, 5, 6, 4, 5, 7};
  int xpn[9] = '{0, 1, 2, 3, 1, 2, 0, 2, 3};
  tcs_top uut (.SYS_CLK(clk), .RESET(rst), .AVS_ADDRESS(addr), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_WRITEDATA(wd), .AVS_READDATA(rdat),
    .AVS_WAITREQUEST(waitreq), .EXT_CLK_PIN(pin), .MATCH_EVT(evt),
    .PHASE_CNT(phase), .CLEARED(cleared));
  tcs_partner pal (.clk(clk), .pin(pin), .evt(evt), .phase(phase));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    for (int i = 0; i < 6; i++) ncl[i] += cleared[i];
  end
  //////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] ra(int ch, logic [7:0] o);
    return 8'(`TCS_CH_BASE + `TCS_CH_STRIDE * ch + o);
  endfunction
  function automatic bit hit(int ch, int c, int e, int md);
    if (ch % 3 != 0) c = c & 3;
    case (c)
      1: return e == 0;
      2: return e == 1;
      5: return ch % 3 == 0 && e == 2 && !md[0];
      6: return ch % 3 == 0 && e == 3 && !md[1];
      default: return 0;
    endcase
  endfunction
  task automatic close_out();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Request held until waitrequest is sampled low, then one idle edge
  task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
    int k;
    k = 0;
    rd <= !w;
    wr <= w;
    addr <= a;
    wd <= d;
    do begin
      @(posedge clk);
      k++;
    end while (waitreq !== 1'b0 && k < 20);
    if (k >= 20) begin
      miscompares++;
      close_out();
    end
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic cfg(int ch, logic [7:0] c, logic [15:0] v);
    bus(1, ra(ch, `TCS_CTRL_OFS), c);
    bus(1, ra(ch, `TCS_COUNT_OFS), v);
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (100000) @(posedge clk);
    miscompares++;
    close_out();
  end
  initial begin
    rst = 1'b1;
    rd = 1'b0;
    wr = 1'b0;
    addr = 8'h00;
    wd = 32'h0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    chk("idle waitrequest", 1, waitreq);
    bus(0, ra(0, `TCS_CTRL_OFS), 0);
    chk("ctrl reset", `TCS_CTRL_RST, q);
    bus(0, 8'hf0, 0);
    chk("unmapped", 0, q);
    // Counters stay stopped here; clears act regardless
    for (int ch = 0; ch < 2; ch++)
      for (int md = 0; md < 4; md += 3)
        for (int c = 0; c < 8; c++)
          for (int e = 0; e < 4; e++) begin
            lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
            bus(1, ra(ch, `TCS_MODE_OFS), md);
            cfg(ch, 8'(c << 5), lfsr | 1);
            bus(0, ra(ch, `TCS_CTRL_OFS), 0);
            chk("ctrl", ch ? (c & 3) << 5 : c << 5, q);
            n = ncl[ch];
            pal.pulse(ch, 4'h1 << e, 0);
            bus(0, ra(ch, `TCS_COUNT_OFS), 0);
            e0 = hit(ch, c, e, md);
            chk("count", e0 ? 0 : lfsr | 1, q);
            chk("cleared", e0, ncl[ch] - n);
          end
    bus(1, ra(0, `TCS_MODE_OFS), 0);
    bus(1, `TCS_START_OFS + 8'h04, 6'h05);
    cfg(0, 8'h20, 16'h0055);
    cfg(1, 8'h60, 16'h0055);
    cfg(2, 8'h60, 16'h0055);
    cfg(3, 8'he0, 16'h0055);
    pal.pulse(0, 4'h1, 0);
    for (int ch = 0; ch < 4; ch++) begin
      bus(0, ra(ch, `TCS_COUNT_OFS), 0);
      chk("sync count", ch[0] ? 16'h0055 : 0, q);
    end
    bus(1, `TCS_SYNC_OFS, 0);
    // Divider phase is unknown, so a count of two either way is allowed
    for (int i = 0; i < 6; i++)
      for (int g = 0; g < 3; g += 2) begin
        cfg(tch[i], 8'(g << 3 | tcd[i]), 0);
        bus(1, `TCS_START_OFS, 1 << tch[i]);
        repeat (2048) @(posedge clk);
        bus(1, `TCS_START_OFS, 0);
        bus(0, ra(tch[i], `TCS_COUNT_OFS), 0);
        n = 2051 / tdv[i] * (g && tdv[i] > 1 ? 2 : 1);
        e0 = q[15:0];
        if (e0 >= n - 2 && e0 <= n + 2) e0 = n;
        chk("int count", n, e0);
      end
    // Nine pin toggles from low: five rising, four falling edges
    for (int i = 0; i < 9; i++)
      for (int g = 0; g < 3; g++) begin
        cfg(xch[i], 8'(g << 3 | xcd[i]), 0);
        bus(1, `TCS_START_OFS, 1 << xch[i]);
        pal.clk_pin(xpn[i], 9, 2 + g);
        repeat (8) @(posedge clk);
        bus(1, `TCS_START_OFS, 0);
        pal.clk_pin(xpn[i], 1, 3);
        bus(0, ra(xch[i], `TCS_COUNT_OFS), 0);
        chk("ext count", g == 2 ? 9 : 5 - g, q);
      end
    cfg(1, 8'h07, 0);
    cfg(4, 8'h07, 0);
    cfg(2, 8'h00, 16'hfff0);
    cfg(5, 8'h00, 16'hfff0);
    bus(1, `TCS_START_OFS, 6'h36);
    repeat (30) @(posedge clk);
    bus(1, `TCS_START_OFS, 0);
    for (int ch = 1; ch < 5; ch += 3) begin
      bus(0, ra(ch, `TCS_COUNT_OFS), 0);
      chk("ovf count", 1, q);
    end
    bus(1, ra(1, `TCS_MODE_OFS), 4);
    cfg(1, 8'h00, 0);
    bus(1, `TCS_START_OFS, 2);
    repeat (7) pal.pulse(1, 0, 1);
    bus(1, `TCS_START_OFS, 0);
    bus(0, ra(1, `TCS_COUNT_OFS), 0);
    chk("phase count", 7, q);
    close_out();
  end
endmodule
